//--- logic/dltc_top.v
// Dual timer/counter with APB register access
//
// Operation
// RQ1: Timer mode counts once per twelve clocks
// RQ2: Division bit picks divide by four or twelve
// RQ3: Counter mode counts external pin falling edges
// RQ4: Pins sampled every clock, edges from samples; code compares the previous sample with the live pin
// RQ5: Overflow flags read-only, cleared on entry
// RQ6: Rollover from all ones sets overflow flag
// RQ7: Run bits enable and stop counting
// RQ8: Pin interrupt flags cleared on routine entry
// RQ9: Gate bit lets gate pin qualify counting
// RQ10: Gated timer counts with run and pin high
// RQ11: Source bit picks external pin or internal
// RQ12: Mode zero is thirteen-bit prescaled counter
// RQ13: Mode one is sixteen-bit cascaded counter
// RQ14: Mode two reloads low byte from high
// RQ15: Mode three splits timer zero in two
// RQ16: Timer one mode three does not split
// RQ17: Software keeps timer one interrupt-free then
// RQ18: Two-bit mode field per timer
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "dltc_defs.vh"

module dltc_top (
	// Clock and reset
	input wire CORE_CLK,
	input wire NRST,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output reg [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR,
	// External count, gate and interrupt pins
	input wire TIMER0_EXT_PIN,
	input wire TIMER1_EXT_PIN,
	input wire TIMER0_GATE_PIN,
	input wire TIMER1_GATE_PIN,
	input wire EXT_PIN0_IRQ_N,
	input wire EXT_PIN1_IRQ_N,
	// Interrupt routine entry strobes from the CPU
	input wire ACK_TIMER0,
	input wire ACK_TIMER1,
	input wire ACK_EXT_PIN0,
	input wire ACK_EXT_PIN1,
	// Flag levels toward the interrupt controller
	output wire TIMER0_OVERFLOW_FLAG,
	output wire TIMER1_OVERFLOW_FLAG,
	output wire EXT_PIN0_IRQ_FLAG,
	output wire EXT_PIN1_IRQ_FLAG
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	reg [7:0] ctrl_flags_ff; // timer_control_flags
	reg [7:0] mode_sel_ff; // timer_mode_select
	reg [7:0] clk_div_ff; // Clock division select bits
	reg [7:0] t0_low_ff; // timer0_low_byte
	reg [7:0] t0_high_ff; // timer0_high_byte
	reg [7:0] t1_low_ff; // timer1_low_byte
	reg [7:0] t1_high_ff; // timer1_high_byte
	reg [5:0] pin_smp_ff; // Previous samples of the six pins

	// ------------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------------
	wire [9:0] idx; // Word index of the access
	wire hit_cf, hit_ms, hit_cd, hit_l0, hit_h0, hit_l1, hit_h1;
	wire hit_any; // Address is mapped
	wire wr_en; // Write takes effect this edge
	wire [7:0] wdat; // Low byte of write data
	reg [7:0] rd_byte; // Read mux result

	assign idx = PADDR[11:2];
	assign hit_cf = (idx == {2'h0, `DLTC_IDX_CTRL_FLAGS});
	assign hit_ms = (idx == {2'h0, `DLTC_IDX_MODE_SEL});
	assign hit_cd = (idx == {2'h0, `DLTC_IDX_CLK_DIV});
	assign hit_l0 = (idx == {2'h0, `DLTC_IDX_T0_LOW});
	assign hit_h0 = (idx == {2'h0, `DLTC_IDX_T0_HIGH});
	assign hit_l1 = (idx == {2'h0, `DLTC_IDX_T1_LOW});
	assign hit_h1 = (idx == {2'h0, `DLTC_IDX_T1_HIGH});
	assign hit_any = hit_cf | hit_ms | hit_cd | hit_l0 | hit_h0 | hit_l1 | hit_h1;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit_any;
	assign wr_en = PSEL & PENABLE & PWRITE & PSTRB[0] & hit_any;
	assign wdat = PWDATA[7:0];

	// Read mux, unmapped reads as zero
	always @* begin
		case (1'b1)
			hit_cf: rd_byte = ctrl_flags_ff;
			hit_ms: rd_byte = mode_sel_ff;
			hit_cd: rd_byte = clk_div_ff & `DLTC_CD_MASK;
			hit_l0: rd_byte = t0_low_ff;
			hit_h0: rd_byte = t0_high_ff;
			hit_l1: rd_byte = t1_low_ff;
			hit_h1: rd_byte = t1_high_ff;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data captured in the setup cycle
	always @(posedge CORE_CLK) begin
		if (!NRST) begin
			PRDATA <= 32'h0;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= {24'h0, rd_byte};
		end
	end

	// ------------------------------------------------------------------------
	// Timer clock ticks
	// ------------------------------------------------------------------------
	wire tick0, tick1; // Divided timer clocks

	dltc_prescale u_pre0 (
		.clk(CORE_CLK),
		.nrst(NRST),
		.div4(clk_div_ff[`DLTC_CD_T0_DIV4]), // RQ2
		.tick(tick0) // RQ1
	);

	dltc_prescale u_pre1 (
		.clk(CORE_CLK),
		.nrst(NRST),
		.div4(clk_div_ff[`DLTC_CD_T1_DIV4]), // RQ2
		.tick(tick1) // RQ1
	);

	// ------------------------------------------------------------------------
	// Pin sampling and edge detection
	// ------------------------------------------------------------------------
	wire fall_t0, fall_t1, fall_x0, fall_x1; // Falling edges

	// Sample every pin once per clock
	always @(posedge CORE_CLK) begin
		if (!NRST) begin
			pin_smp_ff <= 6'h3f;
		end else begin
			pin_smp_ff <= {EXT_PIN1_IRQ_N, EXT_PIN0_IRQ_N, TIMER1_GATE_PIN, TIMER0_GATE_PIN,
				TIMER1_EXT_PIN, TIMER0_EXT_PIN}; // RQ4
		end
	end

	assign fall_t0 = pin_smp_ff[0] & ~TIMER0_EXT_PIN; // RQ3
	assign fall_t1 = pin_smp_ff[1] & ~TIMER1_EXT_PIN; // RQ3
	assign fall_x0 = pin_smp_ff[4] & ~EXT_PIN0_IRQ_N;
	assign fall_x1 = pin_smp_ff[5] & ~EXT_PIN1_IRQ_N;

	// ------------------------------------------------------------------------
	// Count qualification
	// ------------------------------------------------------------------------
	wire [1:0] mode0, mode1; // Mode fields
	wire run0, run1; // Run bits
	wire en0, en1; // Run and gate qualified
	wire inc0, inc1; // Count pulses
	wire split0; // Timer 0 in split mode
	wire inc_h0; // High byte pulse in split mode

	assign mode0 = mode_sel_ff[`DLTC_MS_T0_MODE_HI:`DLTC_MS_T0_MODE_LO]; // RQ18
	assign mode1 = mode_sel_ff[`DLTC_MS_T1_MODE_HI:`DLTC_MS_T1_MODE_LO]; // RQ18
	assign run0 = ctrl_flags_ff[`DLTC_CF_T0_RUN];
	assign run1 = ctrl_flags_ff[`DLTC_CF_T1_RUN];
	assign en0 = run0 & (~mode_sel_ff[`DLTC_MS_T0_GATE] | TIMER0_GATE_PIN); // RQ7 RQ9 RQ10
	assign en1 = run1 & (~mode_sel_ff[`DLTC_MS_T1_GATE] | TIMER1_GATE_PIN); // RQ7 RQ9 RQ10
	assign inc0 = en0 & (mode_sel_ff[`DLTC_MS_T0_SRC] ? fall_t0 : tick0); // RQ11
	assign inc1 = en1 & (mode_sel_ff[`DLTC_MS_T1_SRC] ? fall_t1 : tick1); // RQ11
	assign split0 = (mode0 == `DLTC_MODE_SPLIT);
	assign inc_h0 = run1 & tick0; // RQ15

	// ------------------------------------------------------------------------
	// One count step: returns {overflow, high, low}
	// ------------------------------------------------------------------------
	function [16:0] f_step;
		input [1:0] mode;
		input [7:0] lo;
		input [7:0] hi;
		reg [13:0] c13;
		reg [16:0] c16;
		begin
			c13 = {1'b0, hi, lo[4:0]} + 14'h1;
			c16 = {1'b0, hi, lo} + 17'h1;
			case (mode)
				`DLTC_MODE_13BIT: f_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // RQ12
				`DLTC_MODE_16BIT: f_step = c16; // RQ13
				`DLTC_MODE_RELOAD: begin
					if (lo == 8'hff) begin
						f_step = {1'b1, hi, hi}; // RQ14
					end else begin
						f_step = {1'b0, hi, lo + 8'h1};
					end
				end
				default: f_step = {1'b0, hi, lo}; // RQ16
			endcase
		end
	endfunction

	// ------------------------------------------------------------------------
	// Next counts and overflow events
	// ------------------------------------------------------------------------
	wire [16:0] st0, st1; // Step results
	wire [8:0] sl0, sh0; // Split mode byte sums
	reg [7:0] nxt_l0, nxt_h0, nxt_l1, nxt_h1; // Next count bytes
	reg ovf0, ovf1; // Overflow events for the flags

	assign st0 = f_step(mode0, t0_low_ff, t0_high_ff);
	assign st1 = f_step(mode1, t1_low_ff, t1_high_ff);
	assign sl0 = {1'b0, t0_low_ff} + 9'h1;
	assign sh0 = {1'b0, t0_high_ff} + 9'h1;

	// Timer 0 and timer 1 counting, bus writes take priority
	always @* begin
		nxt_l0 = t0_low_ff;
		nxt_h0 = t0_high_ff;
		nxt_l1 = t1_low_ff;
		nxt_h1 = t1_high_ff;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		if (split0) begin
			// Low byte on timer 0 controls, high byte on timer 1 run bit and timer 0 tick
			if (inc0) begin
				nxt_l0 = sl0[7:0];
				ovf0 = sl0[8]; // RQ15 RQ6
			end
			if (inc_h0) begin
				nxt_h0 = sh0[7:0];
				ovf1 = sh0[8]; // RQ15 RQ6
			end
		end else if (inc0) begin
			nxt_h0 = st0[15:8];
			nxt_l0 = st0[7:0];
			ovf0 = st0[16]; // RQ6
		end
		if (inc1) begin
			nxt_h1 = st1[15:8];
			nxt_l1 = st1[7:0];
			// Timer 1 flag is lent to timer 0 while it is split
			if (!split0) begin
				ovf1 = st1[16]; // RQ6 RQ17
			end
		end
		if (wr_en && hit_l0) begin
			nxt_l0 = wdat;
		end
		if (wr_en && hit_h0) begin
			nxt_h0 = wdat;
		end
		if (wr_en && hit_l1) begin
			nxt_l1 = wdat;
		end
		if (wr_en && hit_h1) begin
			nxt_h1 = wdat;
		end
	end

	// ------------------------------------------------------------------------
	// Control and flag register next value
	// ------------------------------------------------------------------------
	reg [7:0] nxt_cf; // Next timer_control_flags

	// Flags: set wins over clear; overflow flags ignore writes
	always @* begin
		nxt_cf = ctrl_flags_ff;
		if (wr_en && hit_cf) begin
			nxt_cf[`DLTC_CF_T1_RUN] = wdat[`DLTC_CF_T1_RUN]; // RQ7
			nxt_cf[`DLTC_CF_T0_RUN] = wdat[`DLTC_CF_T0_RUN]; // RQ7
			nxt_cf[`DLTC_CF_PIN1_IRQ] = wdat[`DLTC_CF_PIN1_IRQ];
			nxt_cf[`DLTC_CF_PIN0_IRQ] = wdat[`DLTC_CF_PIN0_IRQ];
		end
		if (ACK_TIMER1) begin
			nxt_cf[`DLTC_CF_T1_OVF] = 1'b0; // RQ5
		end
		if (ACK_TIMER0) begin
			nxt_cf[`DLTC_CF_T0_OVF] = 1'b0; // RQ5
		end
		if (ACK_EXT_PIN1) begin
			nxt_cf[`DLTC_CF_PIN1_IRQ] = 1'b0; // RQ8
		end
		if (ACK_EXT_PIN0) begin
			nxt_cf[`DLTC_CF_PIN0_IRQ] = 1'b0; // RQ8
		end
		if (ovf1) begin
			nxt_cf[`DLTC_CF_T1_OVF] = 1'b1; // RQ6
		end
		if (ovf0) begin
			nxt_cf[`DLTC_CF_T0_OVF] = 1'b1; // RQ6
		end
		if (fall_x1) begin
			nxt_cf[`DLTC_CF_PIN1_IRQ] = 1'b1;
		end
		if (fall_x0) begin
			nxt_cf[`DLTC_CF_PIN0_IRQ] = 1'b1;
		end
		nxt_cf[2] = 1'b0;
		nxt_cf[0] = 1'b0;
	end

	// ------------------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------------------
	always @(posedge CORE_CLK) begin
		if (!NRST) begin
			ctrl_flags_ff <= `DLTC_RST_CTRL_FLAGS;
			mode_sel_ff <= `DLTC_RST_MODE_SEL;
			clk_div_ff <= `DLTC_RST_CLK_DIV;
			t0_low_ff <= `DLTC_RST_COUNT;
			t0_high_ff <= `DLTC_RST_COUNT;
			t1_low_ff <= `DLTC_RST_COUNT;
			t1_high_ff <= `DLTC_RST_COUNT;
		end else begin
			ctrl_flags_ff <= nxt_cf;
			t0_low_ff <= nxt_l0;
			t0_high_ff <= nxt_h0;
			t1_low_ff <= nxt_l1;
			t1_high_ff <= nxt_h1;
			// Mode written whole, division masked to its two select bits
			if (wr_en && hit_ms) begin
				mode_sel_ff <= wdat;
			end
			if (wr_en && hit_cd) begin
				clk_div_ff <= wdat & `DLTC_CD_MASK;
			end
		end
	end

	// Flag levels out
	assign TIMER0_OVERFLOW_FLAG = ctrl_flags_ff[`DLTC_CF_T0_OVF];
	assign TIMER1_OVERFLOW_FLAG = ctrl_flags_ff[`DLTC_CF_T1_OVF];
	assign EXT_PIN0_IRQ_FLAG = ctrl_flags_ff[`DLTC_CF_PIN0_IRQ];
	assign EXT_PIN1_IRQ_FLAG = ctrl_flags_ff[`DLTC_CF_PIN1_IRQ];

endmodule // dltc_top
`default_nettype wire

//--- logic/dltc_defs.vh
// Register indices, field positions, reset values and counts of the dual timer/counter
`ifndef DLTC_DEFS_VH
`define DLTC_DEFS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address on APB is four times the index)
// ----------------------------------------------------------------------------
`define DLTC_IDX_CTRL_FLAGS 8'h88
`define DLTC_IDX_MODE_SEL 8'h89
`define DLTC_IDX_T0_LOW 8'h8a
`define DLTC_IDX_T1_LOW 8'h8b
`define DLTC_IDX_T0_HIGH 8'h8c
`define DLTC_IDX_T1_HIGH 8'h8d
`define DLTC_IDX_CLK_DIV 8'h8e

// ----------------------------------------------------------------------------
// Field positions in timer_control_flags
// ----------------------------------------------------------------------------
`define DLTC_CF_T1_OVF 7
`define DLTC_CF_T1_RUN 6
`define DLTC_CF_T0_OVF 5
`define DLTC_CF_T0_RUN 4
`define DLTC_CF_PIN1_IRQ 3
`define DLTC_CF_PIN0_IRQ 1

// ----------------------------------------------------------------------------
// Field positions in timer_mode_select and the clock division register
// ----------------------------------------------------------------------------
`define DLTC_MS_T1_GATE 7
`define DLTC_MS_T1_SRC 6
`define DLTC_MS_T1_MODE_HI 5
`define DLTC_MS_T1_MODE_LO 4
`define DLTC_MS_T0_GATE 3
`define DLTC_MS_T0_SRC 2
`define DLTC_MS_T0_MODE_HI 1
`define DLTC_MS_T0_MODE_LO 0
`define DLTC_CD_T1_DIV4 4
`define DLTC_CD_T0_DIV4 3
`define DLTC_CD_MASK 8'h18

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DLTC_RST_CTRL_FLAGS 8'h00
`define DLTC_RST_MODE_SEL 8'h00
`define DLTC_RST_COUNT 8'h00
`define DLTC_RST_CLK_DIV 8'h00

// ----------------------------------------------------------------------------
// Counting modes and timer clock division counts
// ----------------------------------------------------------------------------
`define DLTC_MODE_13BIT 2'h0
`define DLTC_MODE_16BIT 2'h1
`define DLTC_MODE_RELOAD 2'h2
`define DLTC_MODE_SPLIT 2'h3
`define DLTC_DIV_SLOW 4'hc
`define DLTC_DIV_FAST 4'h4

`endif

//--- logic/dltc_prescale.v
// Timer clock divider: one tick every 12 or every 4 core clocks
`timescale 1ns/1ns
`default_nettype none
`include "dltc_defs.vh"

module dltc_prescale (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Division select, high picks the fast rate
	input wire div4,
	// One-cycle tick
	output wire tick
);

	reg [3:0] cnt_ff; // Cycles since last tick
	reg [3:0] nxt_cnt; // Next cycle count
	wire [3:0] limit; // Selected division factor

	assign limit = div4 ? `DLTC_DIV_FAST : `DLTC_DIV_SLOW;
	assign tick = (cnt_ff >= limit - 4'h1);

	// Next count wraps on the tick
	always @* begin
		if (tick) begin
			nxt_cnt = 4'h0;
		end else begin
			nxt_cnt = cnt_ff + 4'h1;
		end
	end

	// Free-running count register
	always @(posedge clk) begin
		if (!nrst) begin
			cnt_ff <= 4'h0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

endmodule // dltc_prescale
`default_nettype wire

//--- bench/dltc_pins.sv
// Model of the external count and gate pins
`timescale 1ns/1ns
`default_nettype none

module dltc_pins (
	// Clock and controls from the bench
	input wire logic clk,
	input wire logic en,
	input wire logic gate,
	// Pins toward the timers
	output wire logic cnt0,
	output wire logic cnt1,
	output wire logic timer0_gate_qualify,
	output wire logic timer1_gate_qualify
);
	logic [1:0] ph_ff = 2'h0; // Phase within a half period
	logic c_ff = 1'h1; // Count wave level
	// Square wave, three clocks high then three low; rests high so no stray edge
	always @(posedge clk) begin
		ph_ff <= (ph_ff == 2'h2 || !en) ? 2'h0 : ph_ff + 2'h1;
		if (!en) begin
			c_ff <= 1'h1;
		end else if (ph_ff == 2'h2) begin
			c_ff <= !c_ff;
		end
	end
	assign cnt0 = c_ff;
	assign cnt1 = c_ff;
	assign timer0_gate_qualify = gate;
	assign timer1_gate_qualify = gate;
endmodule // dltc_pins

`default_nettype wire

//--- bench/dltc_properties.sv
// Port assertions of the dual timer/counter
`timescale 1ns/1ns
`default_nettype none

module dltc_properties (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic NRST,
	// Bus
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Pins and entry strobes
	input wire logic EXT_PIN0_IRQ_N,
	input wire logic ACK_TIMER0,
	input wire logic ACK_TIMER1,
	input wire logic ACK_EXT_PIN0,
	// Flags
	input wire logic TIMER0_OVERFLOW_FLAG,
	input wire logic TIMER1_OVERFLOW_FLAG,
	input wire logic EXT_PIN0_IRQ_FLAG,
	input wire logic EXT_PIN1_IRQ_FLAG
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// Access phase of a transfer
	sequence s_acc;
		PSEL && PENABLE;
	endsequence
	AST_READY: assert property (PREADY) else $error("ready low");
	AST_ERR_MAP: assert property (s_acc |-> PSLVERR == (PADDR[11:2] < 10'h088 || PADDR[11:2] > 10'h08e))
		else $error("error response wrong");
	AST_ERR_IDLE: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
	AST_T0_HOLD: assert property (TIMER0_OVERFLOW_FLAG && !ACK_TIMER0 |=> TIMER0_OVERFLOW_FLAG)
		else $error("timer0 flag lost");
	AST_T0_ACK: assert property (ACK_TIMER0 |=> !TIMER0_OVERFLOW_FLAG) else $error("timer0 flag kept");
	AST_T1_HOLD: assert property (TIMER1_OVERFLOW_FLAG && !ACK_TIMER1 |=> TIMER1_OVERFLOW_FLAG)
		else $error("timer1 flag lost");
	AST_T1_ACK: assert property (ACK_TIMER1 |=> !TIMER1_OVERFLOW_FLAG) else $error("timer1 flag kept");
	AST_P0_SET: assert property ($fell(EXT_PIN0_IRQ_N) |=> EXT_PIN0_IRQ_FLAG) else $error("pin flag unset");
	AST_P0_ACK: assert property (ACK_EXT_PIN0 && !$fell(EXT_PIN0_IRQ_N) && !(PSEL && PENABLE && PWRITE)
		|=> !EXT_PIN0_IRQ_FLAG) else $error("pin flag kept");
	AST_RST: assert property ($rose(NRST) |-> !(TIMER0_OVERFLOW_FLAG || TIMER1_OVERFLOW_FLAG ||
		EXT_PIN0_IRQ_FLAG || EXT_PIN1_IRQ_FLAG)) else $error("flag after reset");
endmodule // dltc_properties

bind dltc_top dltc_properties dltc_properties_i (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.EXT_PIN0_IRQ_N(EXT_PIN0_IRQ_N), .ACK_TIMER0(ACK_TIMER0), .ACK_TIMER1(ACK_TIMER1),
	.ACK_EXT_PIN0(ACK_EXT_PIN0), .TIMER0_OVERFLOW_FLAG(TIMER0_OVERFLOW_FLAG),
	.TIMER1_OVERFLOW_FLAG(TIMER1_OVERFLOW_FLAG), .EXT_PIN0_IRQ_FLAG(EXT_PIN0_IRQ_FLAG),
	.EXT_PIN1_IRQ_FLAG(EXT_PIN1_IRQ_FLAG));

`default_nettype wire

//--- bench/tb.sv
// Self-checking bench of the dual timer/counter
`timescale 1ns/1ns
`default_nettype none

module tb;
	typedef struct {bit w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic x;} dltc_row_t;
	logic clk = 1'h0; // Core clock
	logic nrst = 1'h0; // Reset, active low
	logic psel = 1'h0; // Bus select
	logic pen = 1'h0; // Bus enable
	logic pwr = 1'h0; // Bus direction
	logic [11:0] padr = 12'h000; // Bus address
	logic [31:0] pwd = 32'h0; // Bus write data
	logic [3:0] ack = 4'h0; // Entry strobes
	logic [1:0] irq_n = 2'h3; // Interrupt pins
	logic en = 1'h0; // Count wave on
	logic gt = 1'h0; // Gate level
	logic [31:0] rd; // Last read data
	logic er; // Last error response
	int failures = 0;
	int n_tests = 0;
	wire c0, c1, g0, g1, rdy, err, f0, f1, p0, p1;
	wire [31:0] prd;
	// Reset values, read-back, refused bits, unmapped word
	dltc_row_t rows[10] = '{'{1'h0, 12'h220, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h224, 8'h00, 8'h00, 1'h0},
		'{1'h0, 12'h238, 8'h00, 8'h00, 1'h0}, '{1'h0, 12'h234, 8'h00, 8'h00, 1'h0},
		'{1'h1, 12'h224, 8'ha5, 8'ha5, 1'h0}, '{1'h1, 12'h228, 8'h3c, 8'h3c, 1'h0},
		'{1'h1, 12'h234, 8'hc3, 8'hc3, 1'h0}, '{1'h1, 12'h23c, 8'h55, 8'h00, 1'h1},
		'{1'h1, 12'h220, 8'hff, 8'h5a, 1'h0}, '{1'h1, 12'h220, 8'h00, 8'h00, 1'h0}};

	dltc_top dltc_top_i (.CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
		.PWDATA(pwd), .PSTRB(4'hf), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err), .TIMER0_EXT_PIN(c0),
		.TIMER1_EXT_PIN(c1), .TIMER0_GATE_PIN(g0), .TIMER1_GATE_PIN(g1), .EXT_PIN0_IRQ_N(irq_n[0]),
		.EXT_PIN1_IRQ_N(irq_n[1]), .ACK_TIMER0(ack[0]), .ACK_TIMER1(ack[1]), .ACK_EXT_PIN0(ack[2]),
		.ACK_EXT_PIN1(ack[3]), .TIMER0_OVERFLOW_FLAG(f0), .TIMER1_OVERFLOW_FLAG(f1),
		.EXT_PIN0_IRQ_FLAG(p0), .EXT_PIN1_IRQ_FLAG(p1));
	dltc_pins dltc_pins_i (.clk(clk), .en(en), .gate(gt), .cnt0(c0), .cnt1(c1), .timer0_gate_qualify(g0), .timer1_gate_qualify(g1));

	always #20 clk = ~clk;

	// Hang guard
	initial begin
		#2000000;
		failures++;
		stop_test();
	end

	task chk(input logic [31:0] s, input logic [31:0] e, input string n);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h saw %h", n, e, s);
		end
	endtask

	// One bus transfer; holds the request until ready is seen
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		padr <= a;
		pwd <= {24'h0, d};
		@(posedge clk);
		pen <= 1'h1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'h1 && n < 50);
		// A slave that never answers counts as a mismatch
		if (n >= 50) begin
			failures++;
		end
		rd = prd;
		er = err;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask

	// Stop, clear timer flags, then load mode, counts and control
	task cfg(input logic t, input logic [7:0] m, input logic [7:0] h, input logic [7:0] l, input logic [7:0] c);
		apb(1'h1, 12'h220, 8'h00);
		@(posedge clk);
		ack <= 4'h3;
		@(posedge clk);
		ack <= 4'h0;
		apb(1'h1, 12'h224, m);
		apb(1'h1, t ? 12'h234 : 12'h230, h);
		apb(1'h1, t ? 12'h22c : 12'h228, l);
		apb(1'h1, 12'h220, c);
	endtask

	// Wait until a timer flag is seen high
	task wt(input logic t);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((t ? f1 : f0) !== 1'h1 && n < 2000);
		// A flag that never rises counts as a mismatch
		if (n >= 2000) begin
			failures++;
		end
	endtask

	// Clocks between two overflows, flag cleared by an entry strobe between them
	task per(input logic t, input int p);
		int n;
		wt(t);
		n = 0;
		do begin
			@(posedge clk);
			ack[t] <= (n == 0);
			#1;
			n++;
		end while (!(n > 2 && (t ? f1 : f0) === 1'h1) && n < 2000);
		chk(n, p, "period");
	endtask

	task stop_test;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				apb(1'h1, rows[i].a, rows[i].d);
			end
			apb(1'h0, rows[i].a, 8'h00);
			chk(rd, {24'h0, rows[i].e}, "register");
			chk(er, rows[i].x, "error");
		end
		$display("registers done");
		cfg(1'h0, 8'h02, 8'hff, 8'hff, 8'h10);
		per(1'h0, 12);
		apb(1'h1, 12'h238, 8'h18);
		// Restart so the period is measured from a fresh rise, not a stale flag
		cfg(1'h0, 8'h02, 8'hff, 8'hff, 8'h10);
		per(1'h0, 4);
		cfg(1'h0, 8'h0a, 8'hff, 8'hff, 8'h10);
		repeat (40) @(posedge clk);
		chk(f0, 1'h0, "gated");
		gt <= 1'h1;
		per(1'h0, 4);
		gt <= 1'h0;
		cfg(1'h0, 8'h06, 8'hff, 8'hff, 8'h10);
		en <= 1'h1;
		per(1'h0, 6);
		en <= 1'h0;
		cfg(1'h1, 8'h20, 8'hff, 8'hff, 8'h40);
		per(1'h1, 4);
		cfg(1'h0, 8'h03, 8'hff, 8'h00, 8'h40);
		per(1'h1, 1024);
		chk(f0, 1'h0, "split low");
		cfg(1'h1, 8'h30, 8'h12, 8'h34, 8'h40);
		repeat (30) @(posedge clk);
		apb(1'h0, 12'h22c, 8'h00);
		chk(rd, 32'h34, "t1 split");
		for (int m = 0; m < 2; m++) begin
			cfg(1'h0, m[7:0], 8'hff, 8'hff, 8'h10);
			wt(1'h0);
			apb(1'h0, 12'h228, 8'h00);
			chk(rd, m ? 32'h0 : 32'he0, "low");
			apb(1'h0, 12'h230, 8'h00);
			chk(rd, 32'h0, "high");
		end
		$display("timers done");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			irq_n[i] <= 1'h0;
			repeat (2) @(posedge clk);
			#1;
			chk(i ? p1 : p0, 1'h1, "pin set");
			@(posedge clk);
			ack[2 + i] <= 1'h1;
			@(posedge clk);
			ack[2 + i] <= 1'h0;
			irq_n[i] <= 1'h1;
			#1;
			chk(i ? p1 : p0, 1'h0, "pin clear");
		end
		apb(1'h1, 12'h220, 8'h50);
		@(posedge clk);
		nrst <= 1'h0;
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		apb(1'h0, 12'h220, 8'h00);
		chk(rd, 32'h0, "reset control");
		$display("pins and reset done");
		stop_test();
	end
endmodule // tb

`default_nettype wire
